//--- design/rss_top.sv
// receive signaling substitution values and received signaling store behind axi4-lite
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "rss_regs.svh"

module rss_top #(
  parameter int NUM_CH = `RSS_NUM_CH
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic [`RSS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`RSS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    rx_sig_valid,
  input  wire logic [`RSS_CHAN_W-1:0]  rx_sig_chan,
  input  wire logic [`RSS_SIG_W-1:0]   rx_sig_abcd,
  input  wire logic                    rx_sf_boundary,
  input  wire logic                    rbs_enable,
  output logic                         sig_out_valid,
  output logic [`RSS_CHAN_W-1:0]       sig_out_chan,
  output logic [`RSS_SIG_W-1:0]        signaling_output_pin
);

  // hit flag and channel index of a word address within a per-channel bank
  function automatic logic [`RSS_CHAN_W:0] bank_decode(
    input logic [`RSS_ADDR_W-1:0] addr,
    input logic [`RSS_ADDR_W-1:0] base
  );
    logic [`RSS_ADDR_W-1:0] diff;
    logic                   hit;
    diff = addr - base;
    hit  = (addr >= base) && (diff[`RSS_ADDR_W-1:2] < (`RSS_ADDR_W-2)'(NUM_CH))
           && (addr[1:0] == 2'b00);
    return {hit, diff[`RSS_CHAN_W+1:2]};
  endfunction

  // substituted value of one channel for a given scheme
  function automatic logic [`RSS_SIG_W-1:0] subst_value(
    input logic [1:0]            sel,
    input logic [`RSS_SIG_W-1:0] val
  );
    logic [`RSS_SIG_W-1:0] res;
    res = 4'hF;
    case (rss_pkg::rss_subst_sel_t'(sel))
      rss_pkg::RSS_SUB_ALL_ONES: res = 4'hF;
      rss_pkg::RSS_SUB_CODE16:   res = val;
      rss_pkg::RSS_SUB_CODE4:    res = {val[3], val[2], val[3], val[2]};
      rss_pkg::RSS_SUB_CODE2:    res = {4{val[3]}};
      default:                   res = 4'hF;
    endcase
    return res;
  endfunction

  // received bits kept by the extraction scheme, the rest forced to zero
  function automatic logic [`RSS_SIG_W-1:0] extract_value(
    input logic [1:0]            sel,
    input logic [`RSS_SIG_W-1:0] val
  );
    logic [`RSS_SIG_W-1:0] res;
    res = 4'h0;
    case (rss_pkg::rss_extract_sel_t'(sel))
      rss_pkg::RSS_EXT_NONE:   res = 4'h0;
      rss_pkg::RSS_EXT_CODE16: res = val;
      rss_pkg::RSS_EXT_CODE4:  res = {val[3:2], 2'b00};
      rss_pkg::RSS_EXT_CODE2:  res = {val[3], 3'b000};
      default:                 res = 4'h0;
    endcase
    return res;
  endfunction

  logic [`RSS_SIG_W-1:0]   subst_r [NUM_CH];
  logic [`RSS_CHCTL_W-1:0] chctl_r [NUM_CH];
  logic [`RSS_SIG_W-1:0]   store_w [NUM_CH];
  logic                    sf_sync_r;

  logic [`RSS_ADDR_W-1:0]  wr_addr_r;
  logic [31:0]             wr_data_r;
  logic [3:0]              wr_strb_r;
  logic                    wr_go;
  logic [`RSS_CHAN_W:0]    wr_sub_dec;
  logic [`RSS_CHAN_W:0]    wr_ctl_dec;
  logic                    wr_frm_hit;
  logic                    wr_hit;
  logic                    wr_low_lane;

  logic [`RSS_CHAN_W:0]    rd_sub_dec;
  logic [`RSS_CHAN_W:0]    rd_ctl_dec;
  logic [`RSS_CHAN_W:0]    rd_sto_dec;
  logic                    rd_frm_hit;
  logic                    rd_go;

  logic                    chan_ok;
  logic [1:0]              cur_sub_sel;
  logic [1:0]              cur_ext_sel;

  // write channel: address and data taken in either order, answered after both
  assign wr_go       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sub_dec  = bank_decode(wr_addr_r, `RSS_SUBST_BASE);
  assign wr_ctl_dec  = bank_decode(wr_addr_r, `RSS_CHCTL_BASE);
  assign wr_frm_hit  = (wr_addr_r == `RSS_FRMCTL_OFF);
  assign wr_hit      = wr_sub_dec[`RSS_CHAN_W] || wr_ctl_dec[`RSS_CHAN_W] || wr_frm_hit;
  assign wr_low_lane = wr_strb_r[0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      wr_addr_r     <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      wr_addr_r     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_wready <= 1'b1;
      wr_data_r    <= 32'h0000_0000;
      wr_strb_r    <= 4'h0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      wr_data_r    <= s_axi_wdata;
      wr_strb_r    <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // substitution values, low nibble only, upper bits dropped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        subst_r[i] <= `RSS_SIG_RESET;
      end
    end else if (wr_go && wr_low_lane && wr_sub_dec[`RSS_CHAN_W]) begin
      subst_r[wr_sub_dec[`RSS_CHAN_W-1:0]] <= wr_data_r[`RSS_SIG_W-1:0];
    end
  end

  // per-channel scheme selects and debounce enable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        chctl_r[i] <= `RSS_CHCTL_RESET;
      end
    end else if (wr_go && wr_low_lane && wr_ctl_dec[`RSS_CHAN_W]) begin
      chctl_r[wr_ctl_dec[`RSS_CHAN_W-1:0]] <= wr_data_r[`RSS_CHCTL_W-1:0];
    end
  end

  // superframe-boundary update control
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sf_sync_r <= 1'b0;
    end else if (wr_go && wr_low_lane && wr_frm_hit) begin
      sf_sync_r <= wr_data_r[`RSS_FRMCTL_SFSYNC];
    end
  end

  // read channel: one read at a time, data one edge after the address
  assign rd_go      = s_axi_arready && s_axi_arvalid;
  assign rd_sub_dec = bank_decode(s_axi_araddr, `RSS_SUBST_BASE);
  assign rd_ctl_dec = bank_decode(s_axi_araddr, `RSS_CHCTL_BASE);
  assign rd_sto_dec = bank_decode(s_axi_araddr, `RSS_STORE_BASE);
  assign rd_frm_hit = (s_axi_araddr == `RSS_FRMCTL_OFF);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RSS_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rresp <= `RSS_RESP_OKAY;
      if (rd_sub_dec[`RSS_CHAN_W]) begin
        s_axi_rdata <= {28'h000_0000, subst_r[rd_sub_dec[`RSS_CHAN_W-1:0]]};
      end else if (rd_sto_dec[`RSS_CHAN_W]) begin
        s_axi_rdata <= {28'h000_0000, store_w[rd_sto_dec[`RSS_CHAN_W-1:0]]};
      end else if (rd_ctl_dec[`RSS_CHAN_W]) begin
        s_axi_rdata <= {27'h000_0000, chctl_r[rd_ctl_dec[`RSS_CHAN_W-1:0]]};
      end else if (rd_frm_hit) begin
        // robbed-bit state shown so software knows whether the store means anything
        s_axi_rdata <= {24'h00_0000, sf_sync_r, 6'h00, rbs_enable};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RSS_RESP_SLVERR;
      end
    end
  end

  // receive sample path
  assign chan_ok     = rx_sig_valid && (rx_sig_chan < `RSS_CHAN_W'(NUM_CH));
  assign cur_sub_sel = chan_ok ? chctl_r[rx_sig_chan][`RSS_CHCTL_SUB_LSB +: 2] : 2'b00;
  assign cur_ext_sel = chan_ok ? chctl_r[rx_sig_chan][`RSS_CHCTL_EXT_LSB +: 2] : 2'b00;

  // substituted signaling towards the output pin
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sig_out_valid        <= 1'b0;
      sig_out_chan         <= '0;
      signaling_output_pin <= `RSS_SIG_RESET;
    end else begin
      sig_out_valid <= chan_ok;
      if (chan_ok) begin
        sig_out_chan         <= rx_sig_chan;
        signaling_output_pin <= subst_value(cur_sub_sel, subst_r[rx_sig_chan]);
      end
    end
  end

  // one store entry per channel, fed only when extraction is on
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    logic ext_on;
    assign ext_on = chan_ok && (rx_sig_chan == `RSS_CHAN_W'(ch))
                    && (cur_ext_sel != rss_pkg::RSS_EXT_NONE);
    rss_chan_store u_store (
      .clk_sys         (clk_sys),
      .reset           (reset),
      .sample_valid    (ext_on),
      .sample_abcd     (extract_value(cur_ext_sel, rx_sig_abcd)),
      .sf_boundary     (rx_sf_boundary),
      .debounce_enable (chctl_r[ch][`RSS_CHCTL_DEB]),
      .sf_sync         (sf_sync_r),
      .store_r         (store_w[ch])
    );
  end

endmodule
`default_nettype wire

//--- common/rss_regs.svh
// register offsets, field positions, reset values and counts of the signaling array
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_NUM_CH         24
`define RSS_CHAN_W         5
`define RSS_ADDR_W         16
// register indices; each register is one word, its byte address four times its index
`define RSS_SUBST_IDX      16'h03C0
`define RSS_STORE_IDX      16'h0500
`define RSS_CHCTL_IDX      16'h0380
`define RSS_FRMCTL_IDX     16'h0107
`define RSS_SUBST_BASE     (`RSS_SUBST_IDX * 16'h0004)
`define RSS_STORE_BASE     (`RSS_STORE_IDX * 16'h0004)
`define RSS_CHCTL_BASE     (`RSS_CHCTL_IDX * 16'h0004)
`define RSS_FRMCTL_OFF     (`RSS_FRMCTL_IDX * 16'h0004)
`define RSS_FRMCTL_SFSYNC  7
`define RSS_FRMCTL_RBS     0
`define RSS_CHCTL_EXT_LSB  0
`define RSS_CHCTL_SUB_LSB  2
`define RSS_CHCTL_DEB      4
`define RSS_CHCTL_W        5
`define RSS_SIG_W          4
`define RSS_SIG_RESET      4'h0
`define RSS_CHCTL_RESET    5'h00
`define RSS_RESP_OKAY      2'h0
`define RSS_RESP_SLVERR    2'h2

`endif

//--- common/rss_pkg.sv
// types of the receive signaling substitution array
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_SUB_ALL_ONES = 2'b00,
    RSS_SUB_CODE16   = 2'b01,
    RSS_SUB_CODE4    = 2'b10,
    RSS_SUB_CODE2    = 2'b11
  } rss_subst_sel_t;

  typedef enum logic [1:0] {
    RSS_EXT_NONE   = 2'b00,
    RSS_EXT_CODE16 = 2'b01,
    RSS_EXT_CODE4  = 2'b10,
    RSS_EXT_CODE2  = 2'b11
  } rss_extract_sel_t;

endpackage

//--- design/rss_chan_store.sv
// one channel of the received signaling store with two-superframe debounce
`timescale 1ns/100ps
`default_nettype none
`include "rss_regs.svh"

module rss_chan_store (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   sample_valid,
  input  wire logic [`RSS_SIG_W-1:0]  sample_abcd,
  input  wire logic                   sf_boundary,
  input  wire logic                   debounce_enable,
  input  wire logic                   sf_sync,
  output logic      [`RSS_SIG_W-1:0]  store_r
);

  logic [`RSS_SIG_W-1:0] cur_sf_r;
  logic [`RSS_SIG_W-1:0] prev_sf_r;
  logic                  immediate;

  assign immediate = !debounce_enable || !sf_sync;

  // latest state seen within the running superframe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur_sf_r <= `RSS_SIG_RESET;
    end else if (sample_valid) begin
      cur_sf_r <= sample_abcd;
    end
  end

  // state held by the superframe just closed
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_sf_r <= `RSS_SIG_RESET;
    end else if (sf_boundary) begin
      prev_sf_r <= cur_sf_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      store_r <= `RSS_SIG_RESET;
    end else if (immediate) begin
      if (sample_valid) begin
        store_r <= sample_abcd;
      end
    end else if (sf_boundary && (cur_sf_r == prev_sf_r)) begin
      store_r <= cur_sf_r;
    end
    // differing superframes leave the entry as it stands
  end

endmodule
`default_nettype wire

//--- tb/rss_sig_source.sv
// receive framer model that delivers signaling samples and superframe ends
`timescale 1ns/100ps
`default_nettype none
module rss_sig_source (
  input  wire logic       clk_sys,
  output logic            rx_sig_valid,
  output logic [4:0]      rx_sig_chan,
  output logic [3:0]      rx_sig_abcd,
  output logic            rx_sf_boundary
);
  initial begin
    rx_sig_valid = 1'b0;
    rx_sig_chan = 5'h00;
    rx_sig_abcd = 4'h0;
    rx_sf_boundary = 1'b0;
  end
  // one sample, a in bit 3 down to d in bit 0; stale data is inverted
  task automatic send(input logic [4:0] ch, input logic [3:0] v);
    @(posedge clk_sys);
    rx_sig_valid <= 1'b1;
    rx_sig_chan <= ch;
    rx_sig_abcd <= v;
    @(posedge clk_sys);
    rx_sig_valid <= 1'b0;
    rx_sig_abcd <= ~v;
  endtask
  task automatic sf_end();
    @(posedge clk_sys);
    rx_sf_boundary <= 1'b1;
    @(posedge clk_sys);
    rx_sf_boundary <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/rss_top_monitor.sv
// port assertions of the signaling array block
`timescale 1ns/100ps
`default_nettype none
module rss_top_monitor #(
  parameter int NUM_CH = 24
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_sig_valid,
  input wire logic [4:0]  rx_sig_chan,
  input wire logic        sig_out_valid,
  input wire logic [4:0]  sig_out_chan
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_smp_taken;
    rx_sig_valid && (rx_sig_chan < NUM_CH);
  endsequence
  a_write_answer: assert property (
    s_wr_taken |=> s_wr_answer) else $error("write not answered");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_read_answer: assert property (
    s_rd_taken |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  a_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_sample_echo: assert property (
    s_smp_taken |=> sig_out_valid && sig_out_chan == $past(rx_sig_chan))
    else $error("sample not echoed");
  a_bad_chan: assert property (
    rx_sig_valid && rx_sig_chan >= NUM_CH |=> !sig_out_valid) else $error("bad channel used");
  a_echo_pulse: assert property (
    !rx_sig_valid |=> !sig_out_valid) else $error("echo without sample");
  a_reset_idle: assert property (
    $fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid && !sig_out_valid)
    else $error("busy after reset");
endmodule
bind rss_top rss_top_monitor #(.NUM_CH(NUM_CH)) u_rss_top_monitor (.clk_sys, .reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .rx_sig_valid, .rx_sig_chan, .sig_out_valid, .sig_out_chan);
`default_nettype wire

//--- tb/rss_top_tb_top.sv
// self-checking bench of the signaling array block
`timescale 1ns/100ps
`default_nettype none
`include "rss_regs.svh"
module rss_top_tb_top;
  typedef struct packed {
    logic [1:0] sub;
    logic [1:0] ext;
    logic [3:0] val;
    logic [3:0] abcd;
    logic [3:0] pin;
    logic [3:0] store;
  } rss_row_t;
  rss_row_t    rows [4] = '{'{2'b00, 2'b00, 4'h5, 4'hA, 4'hF, 4'h0},
    '{2'b01, 2'b01, 4'h6, 4'hB, 4'h6, 4'hB}, '{2'b10, 2'b10, 4'h9, 4'hD, 4'hA, 4'hC},
    '{2'b11, 2'b11, 4'h7, 4'h9, 4'h0, 4'h8}};
  logic [3:0]  dv [5] = '{4'h3, 4'h3, 4'h6, 4'h5, 4'h5};
  logic [3:0]  dx [5] = '{4'h0, 4'h3, 4'h3, 4'h3, 4'h5};
  localparam logic [1:0] ok = `RSS_RESP_OKAY;
  logic        clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, rx_sig_valid, rx_sf_boundary, rbs_enable, sig_out_valid;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, rx_sig_abcd, signaling_output_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  rx_sig_chan, sig_out_chan;
  int          num_errors, samples_checked;
  rss_top #(.NUM_CH(24)) u_rss_top (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_sig_valid, .rx_sig_chan, .rx_sig_abcd,
    .rx_sf_boundary, .rbs_enable, .sig_out_valid, .sig_out_chan, .signaling_output_pin);
  rss_sig_source u_rss_sig_source (.clk_sys, .rx_sig_valid, .rx_sig_chan, .rx_sig_abcd,
    .rx_sf_boundary);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] ad(input logic [15:0] b, input int ch);
    return b + 16'(4 * ch);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er), "bresp");
  endtask
  task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed, "rdata");
    check(32'(s_axi_rresp), 32'(er), "rresp");
  endtask
  task automatic sample(input logic [4:0] ch, input logic [3:0] v, input logic [3:0] ep);
    u_rss_sig_source.send(ch, v);
    @(posedge clk_sys);
    check(32'(sig_out_valid), 32'h1, "echo");
    check(32'(signaling_output_pin), 32'(ep), "pin");
    check(32'(sig_out_chan), 32'(ch), "chan");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  initial begin
    logic [4:0] ch;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    rbs_enable = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    axi_rd(ad(`RSS_SUBST_BASE, 23), 32'h0, ok);
    axi_rd(ad(`RSS_STORE_BASE, 0), 32'h0, ok);
    for (int i = 0; i < 4; i++) begin
      ch = 5'(i * 7);
      axi_wr(ad(`RSS_CHCTL_BASE, ch), 32'({rows[i].sub, rows[i].ext}), ok);
      axi_wr(ad(`RSS_SUBST_BASE, ch), 32'hFFFF_FFF0 | 32'(rows[i].val), ok);
      axi_rd(ad(`RSS_SUBST_BASE, ch), 32'(rows[i].val), ok);
      sample(ch, rows[i].abcd, rows[i].pin);
      axi_rd(ad(`RSS_STORE_BASE, ch), 32'(rows[i].store), ok);
    end
    axi_rd(16'h0FFC, 32'h0, `RSS_RESP_SLVERR);
    axi_wr(ad(`RSS_STORE_BASE, 7), 32'hF, `RSS_RESP_SLVERR);
    axi_rd(ad(`RSS_STORE_BASE, 7), 32'hB, ok);
    u_rss_sig_source.send(5'd24, 4'h3);
    @(posedge clk_sys);
    check(32'(sig_out_valid), 32'h0, "bad chan");
    rbs_enable <= 1'b1;
    axi_wr(`RSS_FRMCTL_OFF, 32'h80, ok);
    axi_rd(`RSS_FRMCTL_OFF, 32'h81, ok);
    axi_wr(ad(`RSS_CHCTL_BASE, 2), 32'h15, ok);
    for (int i = 0; i < 5; i++) begin
      sample(5'd2, dv[i], 4'h0);
      axi_rd(ad(`RSS_STORE_BASE, 2), 32'(i > 0 ? dx[i - 1] : 4'h0), ok);
      u_rss_sig_source.sf_end();
      axi_rd(ad(`RSS_STORE_BASE, 2), 32'(dx[i]), ok);
    end
    axi_wr(`RSS_FRMCTL_OFF, 32'h0, ok);
    sample(5'd2, 4'h9, 4'h0);
    axi_rd(ad(`RSS_STORE_BASE, 2), 32'h9, ok);
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    axi_rd(ad(`RSS_SUBST_BASE, 7), 32'h0, ok);
    axi_rd(ad(`RSS_STORE_BASE, 2), 32'h0, ok);
    axi_rd(ad(`RSS_CHCTL_BASE, 2), 32'h0, ok);
    axi_rd(`RSS_FRMCTL_OFF, 32'h1, ok);
    close_out();
  end
endmodule
`default_nettype wire
